/* File: dv/sbc_host_spi.sv */
/* host model: spi master, mode 0, msb first.
   sck of 8 system clocks, still between frames. */
module sbc_host_spi
    import sbc_pkg::*;
(
    input  wire logic clk,         // clock
    input  wire logic spiSdo,      // sdo
    output logic      spiSck,      // sck
    output logic      spiSdi,      // sdi
    output logic      spiSelect_n  // select
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        spiSck = 1'b0;
        spiSdi = 1'b1;
        spiSelect_n = 1'b1;
    end
    task automatic xfer(input sbc_spi_frame_type f, output logic [7:0] rv);
        @(posedge clk) #1 spiSelect_n = 1'b0;
        for (int i = 15; i >= 0; i--) begin
            spiSdi = f[i];
            repeat (4) @(posedge clk);
            #1 spiSck = 1'b1;
            if (i < 8) rv[i] = spiSdo;
            repeat (4) @(posedge clk);
            #1 spiSck = 1'b0;
        end
        repeat (4) @(posedge clk);
        #1 spiSelect_n = 1'b1;
        // released line shows no stale bit
        spiSdi = ~spiSdi;
        repeat (8) @(posedge clk);
        #1;
    endtask
endmodule

/* File: dv/sbc_omc_props.sv */
/* checker: output relations of the mode controller.
   bound to its top ports; clock rate taken from the package. */
module sbc_omc_props
    import sbc_pkg::*;
#(
    parameter int STARTUP_US   = 1000,
    parameter int RST_PULSE_US = 1000
) (
    input wire logic clk,          // clock
    input wire logic rst_n,        // reset
    input wire logic batOk,        // battery ok
    input wire logic tempOver,     // overtemp
    input wire logic mcuSupplyUv,  // mcu uv
    input wire logic spiSdoOe,     // sdo on
    input wire logic resetLineOe,  // line low
    input wire logic mcuSupplyEn,  // mcu on
    input wire logic auxSupplyEn,  // aux on
    input wire logic canTxEn,      // tx on
    input wire logic canBiasEn,    // bias on
    input wire logic tempProtEn    // prot on
);
    localparam int STUP_LO  = STARTUP_US * CLK_MHZ - 2;
    localparam int STUP_HI  = STUP_LO + 12;
    localparam int PULSE_LO = RST_PULSE_US * CLK_MHZ - 2;
    logic [15:0] oeCnt;

    // ========================================
    // cycles the line has been pulled low
    always_ff @(posedge clk) begin
        if (!rst_n || !resetLineOe) oeCnt <= 16'h0000;
        else if (oeCnt != 16'hFFFF) oeCnt <= oeCnt + 16'h0001;
    end

    // ========================================
    // properties
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rst_n);
    sequence s_uv_held; mcuSupplyUv [*8] ##0 mcuSupplyEn; endsequence
    property p_rst_spi; resetLineOe |-> !spiSdoOe; endproperty
    a_rst_spi: assert property (p_rst_spi) else $error("spi in reset");
    property p_sleep; !mcuSupplyEn && canBiasEn |-> !tempProtEn && !spiSdoOe;
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep outputs");
    property p_otemp; tempProtEn && !mcuSupplyEn |->
        !auxSupplyEn && !canBiasEn && !canTxEn; endproperty
    a_otemp: assert property (p_otemp) else $error("overtemp outputs");
    property p_ot_entry; $rose(tempOver) && mcuSupplyEn && tempProtEn |->
        ##[1:6] !mcuSupplyEn; endproperty
    a_ot_entry: assert property (p_ot_entry) else $error("no overtemp");
    property p_bat_off; $fell(batOk) |-> ##[1:6] !mcuSupplyEn && !canBiasEn;
    endproperty
    a_bat_off: assert property (p_bat_off) else $error("no off");
    property p_startup; $rose(batOk) |->
        ##[STUP_LO:STUP_HI] $rose(mcuSupplyEn); endproperty
    a_startup: assert property (p_startup) else $error("startup time");
    property p_pulse; $fell(resetLineOe) |-> oeCnt >= PULSE_LO; endproperty
    a_pulse: assert property (p_pulse) else $error("reset pulse short");
    property p_uv; s_uv_held |-> resetLineOe; endproperty
    a_uv: assert property (p_uv) else $error("uv not held");
endmodule

/* File: dv/sbc_operating_mode_controller_test.sv */
/* bench: boot, mode walk and register access of the controller.
   host model drives spi; the reset line has a pull-up. */
module sbc_operating_mode_controller_test
    import sbc_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    logic clk, rst_n, batOk, tempWarn, tempOver, mcuSupplyUv;
    logic canWakeDet, hostPull, wdgReq, rxBit;
    logic [7:0] rv;
    int fails, checkCount;
    wire logic spiSck, spiSdi, spiSelect_n, spiSdo, spiSdoOe;
    wire logic resetLineOut, resetLineOe, busReceive, mcuSupplyEn;
    wire logic auxSupplyEn, canTxEn, canRxEn, canBiasEn, tempProtEn, wdgEnable;
    wire logic lineLvl = !(hostPull || (resetLineOe && !resetLineOut));
    wire logic [7:0] en = {mcuSupplyEn, auxSupplyEn, canTxEn, canRxEn,
                           canBiasEn, tempProtEn, wdgEnable, resetLineOe};

    sbc_operating_mode_controller #(.STARTUP_US(5), .RST_PULSE_US(5)) uut (
        .clk, .rst_n, .batOk, .tempWarn, .tempOver, .mcuSupplyUv,
        .canSupplyUv(1'b0), .canWakeDet, .localWakeDet(1'b0),
        .diagWakeDet(1'b0), .wdgResetReq(wdgReq), .canRxBit(rxBit),
        .spiSck, .spiSdi, .spiSelect_n, .spiSdo, .spiSdoOe,
        .resetLineIn(lineLvl), .resetLineOut, .resetLineOe, .busReceive,
        .mcuSupplyEn, .auxSupplyEn, .canTxEn, .canRxEn, .canBiasEn,
        .tempProtEn, .wdgEnable);
    sbc_host_spi host (.clk, .spiSdo, .spiSck, .spiSdi, .spiSelect_n);

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic completeRun;
        $display("checks %0d mismatches %0d", checkCount, fails);
        if (fails == 0 && checkCount > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checkCount++;
        if (seen !== exp) begin
            fails++;
            $display("MISMATCH at %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        host.xfer(sbc_spi_frame_type'{a, 1'b0, d}, rv);
    endtask
    task automatic rd(input logic [6:0] a, input logic [7:0] m, exp);
        host.xfer(sbc_spi_frame_type'{a, 1'b1, 8'h00}, rv);
        check(rv & m, exp);
    endtask
    // wait for the reset pulse to end, then for the mode to settle
    task automatic waitUp;
        int n;
        n = 0;
        while (resetLineOe !== 1'b0 && n < 400) begin
            tick(1);
            n++;
        end
        tick(6);
        check(8'(resetLineOe), 8'h00);
    endtask

    task automatic tBoot;
        tick(4);
        check(en, 8'h01); // off state
        batOk = 1'b1;
        waitUp();
        check(en & 8'hF3, 8'hF0); // forced normal
        rd(ADDR_NV, 8'hFF, NV_RST); // preset
        rd(ADDR_MODE, 8'hFF, 8'h00); // read refused
        rd(ADDR_MAIN, 8'hFF, 8'h20); // power-on status
        wr(ADDR_NV, 8'h00); // nv write while preset
    endtask
    task automatic tStandby;
        hostPull = 1'b1;
        tick(8);
        check(en & 8'hB3, 8'h81); // reset outputs
        hostPull = 1'b0;
        waitUp();
        check(en & 8'hB1, 8'h80); // standby
        rd(ADDR_MAIN, 8'hFF, 8'h31); // external reset cause
        wr(ADDR_MODE, {5'h00, MODE_NORM});
        rd(ADDR_MODE, 8'hFF, 8'h07); // normal
        wr(ADDR_CAN, 8'h01);
        check(en & 8'h30, 8'h30); // transceiver active
        rxBit = 1'b1;
        tick(4);
        check(8'(busReceive), 8'h01); // bit stream
        rxBit = 1'b0;
        tick(4);
        check(8'(busReceive), 8'h00); // bit stream
        wr(ADDR_MODE, 8'hFA);
        rd(ADDR_MODE, 8'hFF, 8'h07); // code ignored
        rd(ADDR_MAIN, 8'h20, 8'h00); // normal entered
        wr(ADDR_MODE, {5'h00, MODE_STBY});
        rd(ADDR_MODE, 8'hFF, 8'h04); // standby
        wdgReq = 1'b1;
        tick(6);
        wdgReq = 1'b0;
        waitUp();
        rd(ADDR_MAIN, 8'h1F, 8'h0F); // watchdog cause
    endtask
    task automatic tSleep;
        wr(ADDR_MODE, {5'h00, MODE_SLEEP});
        check(en & 8'h8C, 8'h08); // sleep outputs
        canWakeDet = 1'b1;
        tick(6);
        canWakeDet = 1'b0;
        waitUp();
        check(en & 8'hB1, 8'h80); // back in standby
        check(8'(busReceive), 8'h00); // wake shown low
        rd(ADDR_MAIN, 8'h1F, 8'h01); // wake cause
        wr(ADDR_MODE, {5'h00, MODE_SLEEP});
        waitUp();
        rd(ADDR_MAIN, 8'h1F, 8'h14); // illegal sleep
        wr(ADDR_EVENT, 8'h07);
        check(8'(busReceive), 8'h01); // released on clear
    endtask
    task automatic tTemp;
        tempWarn = 1'b1;
        tick(4);
        rd(ADDR_MAIN, 8'h40, 8'h40); // warning status
        rd(ADDR_EVENT, 8'h02, 8'h00); // event masked
        tempOver = 1'b1;
        tick(6);
        check(en & 8'hF9, 8'h01); // overtemp outputs
        tempOver = 1'b0;
        tempWarn = 1'b0;
        waitUp();
        rd(ADDR_MAIN, 8'h1F, 8'h12); // left overtemp
        mcuSupplyUv = 1'b1;
        tick(120);
        check(8'(resetLineOe), 8'h01); // held in reset
        mcuSupplyUv = 1'b0;
        waitUp();
        batOk = 1'b0;
        tick(6);
        check(en, 8'h01); // battery loss
        batOk = 1'b1;
        waitUp();
        rd(ADDR_MAIN, 8'h1F, 8'h00); // power-on cause
    endtask

    initial begin
        {rst_n, batOk, tempWarn, tempOver, mcuSupplyUv} = 5'h00;
        {canWakeDet, hostPull, wdgReq, rxBit} = 4'h0;
        fails = 0;
        checkCount = 0;
        tick(5);
        rst_n = 1'b1;
        tBoot();
        tStandby();
        tSleep();
        tTemp();
        completeRun();
    end
    initial begin
        #3_000_000;
        fails++;
        completeRun();
    end
endmodule

bind sbc_operating_mode_controller sbc_omc_props #(
    .STARTUP_US(STARTUP_US), .RST_PULSE_US(RST_PULSE_US)) props (
    .clk, .rst_n, .batOk, .tempOver, .mcuSupplyUv, .spiSdoOe, .resetLineOe,
    .mcuSupplyEn, .auxSupplyEn, .canTxEn, .canBiasEn, .tempProtEn);

/* File: pkg/sbc_pkg.sv */
/*
 * Constants, types and register map of the operating-mode controller.
 * Assumes a 10 MHz system clock and a 16-bit SPI frame driven by the host.
 */
//
// Operation
// (R01) Mode write 100 in Normal enters Standby.
// (R02) Mode write 111 in Standby enters Normal.
// (R03) Mode write 001 sleeps only with no pending wake and a wake source enabled.
// (R04) Illegal sleep request goes to Reset, cause 10100.
// (R05) Sleep: mcu supply off, temperature protection off, SPI off, biasing on.
// (R06) Sleep left only on enabled wake-up, via Reset into Standby.
// (R07) Sleep inhibit set: sleep write raises SPI fail, mode unchanged.
// (R08) Any reset event enters Reset from any mode; code does so only from Standby, Normal and Forced Normal.
// (R09) Reset: line low for set time, CAN offline, SPI off, supply on.
// (R10) Reset exits to Standby once the reset line reads high.
// (R11) Forced normal config set: Reset exits to Forced Normal instead.
// (R12) Reset from mcu undervoltage holds until supply recovers.
// (R13) Off on battery loss; Reset after startup delay on recovery.
// (R14) Overtemp entered at once from all modes but Off and Sleep.
// (R15) Warning temperature sets warn state; event captured if enabled.
// (R16) Overtemp: no new wakes, pending wake kept low, all off, line low.
// (R17) Overtemp exits to Reset on cooling, to Off on battery loss.
// (R18) Forced Normal: watchdog off, both supplies and CAN active.
// (R19) Forced normal config is non-volatile at 74h, preset to 1.
// (R20) Reset from Forced Normal keeps CAN transmitter unless CAN undervoltage.
// (R21) Forced Normal: reads limited; non-volatile writes while preset.
// (R22) Normal: receive pin carries CAN data when CAN mode nonzero.
// (R23) Mode select is bits 2:0 at 01h; bits 7:3 read zero.
// (R24) Main status shows warn state, Normal-entered flag, reset cause.
// (R25) Standby: receive pin low on any enabled detected wake.
// (R26) Other mode codes leave the mode unchanged.
package sbc_pkg;

    // =========================================================
    // timing
    localparam int CLK_MHZ      = 10;
    localparam int CNT_W        = 24;

    // =========================================================
    // register addresses
    localparam logic [6:0] ADDR_MODE  = 7'h01;
    localparam logic [6:0] ADDR_MAIN  = 7'h03;
    localparam logic [6:0] ADDR_WCFG  = 7'h04;
    localparam logic [6:0] ADDR_AUX   = 7'h10;
    localparam logic [6:0] ADDR_CAN   = 7'h20;
    localparam logic [6:0] ADDR_EVENT = 7'h61;
    localparam logic [6:0] ADDR_NV    = 7'h74;

    // =========================================================
    // field positions and reset values
    localparam int BIT_CAN_WAKE_EN  = 0;
    localparam int BIT_LOC_WAKE_EN  = 1;
    localparam int BIT_OTW_IRQ_EN   = 2;
    localparam int BIT_EV_SPI_FAIL  = 0;
    localparam int BIT_EV_OTW       = 1;
    localparam int BIT_EV_WAKE      = 2;
    localparam int BIT_NV_FORCED_NORMAL_CFG      = 0;
    localparam int BIT_NV_SLEEP_INH = 1;
    localparam logic [7:0] WCFG_RST = 8'h03;
    localparam logic [7:0] NV_RST   = 8'h01;

    // =========================================================
    // mode codes and reset causes
    localparam logic [2:0] MODE_SLEEP = 3'b001;
    localparam logic [2:0] MODE_STBY  = 3'b100;
    localparam logic [2:0] MODE_NORM  = 3'b111;
    localparam logic [4:0] RSS_POWER_ON = 5'b00000;
    localparam logic [4:0] RSS_CAN_WAKE = 5'b00001;
    localparam logic [4:0] RSS_LOC_WAKE = 5'b00100;
    localparam logic [4:0] RSS_DIAG     = 5'b01101;
    localparam logic [4:0] RSS_WDG      = 5'b01111;
    localparam logic [4:0] RSS_EXT_RST  = 5'b10001;
    localparam logic [4:0] RSS_OTEMP    = 5'b10010;
    localparam logic [4:0] RSS_MCU_UV   = 5'b10011;
    localparam logic [4:0] RSS_ILL_SLP  = 5'b10100;

    // =========================================================
    // synchroniser lanes and their reset levels
    localparam int SYNC_W = 14;
    localparam logic [SYNC_W-1:0] SYNC_RST = 14'h0002;
    localparam logic [4:0] SPI_BITS = 5'd16;
    localparam logic [4:0] SPI_HDR  = 5'd8;

    typedef enum logic [2:0] {
        SBC_OFF   = 3'b000,
        SBC_RESET = 3'b001,
        SBC_STBY  = 3'b010,
        SBC_NORM  = 3'b011,
        SBC_SLEEP = 3'b100,
        SBC_FNORM = 3'b101,
        SBC_OTEMP = 3'b110
    } sbc_mode_type;

    typedef struct packed {
        logic [6:0] addr;
        logic       readOnly;
        logic [7:0] data;
    } sbc_spi_frame_type;

    typedef struct packed {
        logic mcuSupplyEn;
        logic auxSupplyEn;
        logic canTxEn;
        logic canRxEn;
        logic canBiasEn;
        logic tempProtEn;
        logic wdgEnable;
        logic spiActive;
    } sbc_ctrl_type;

endpackage

/* File: rtl/sbc_operating_mode_controller.sv */
/*
 * Operating-mode state machine with SPI register access.
 * Assumes all inputs but clk and rst_n are asynchronous pins and the reset line is open drain.
 */
module sbc_operating_mode_controller
    import sbc_pkg::*;
#(
    parameter int STARTUP_US   = 1000,
    parameter int RST_PULSE_US = 1000
) (
    input  wire logic clk,           // 10 MHz system clock
    input  wire logic rst_n,         // synchronous power-on reset
    input  wire logic batOk,         // battery above power-on threshold
    input  wire logic tempWarn,      // above warning temperature
    input  wire logic tempOver,      // above protection threshold
    input  wire logic mcuSupplyUv,   // mcu supply undervoltage
    input  wire logic canSupplyUv,   // CAN supply undervoltage
    input  wire logic canWakeDet,    // CAN wake pattern seen
    input  wire logic localWakeDet,  // local wake pin event
    input  wire logic diagWakeDet,   // diagnostic wake event
    input  wire logic wdgResetReq,   // watchdog reset request
    input  wire logic canRxBit,      // receiver bit stream
    input  wire logic spiSck,        // SPI clock
    input  wire logic spiSdi,        // SPI data in
    input  wire logic spiSelect_n,   // SPI chip select
    output logic      spiSdo,        // SPI data out
    output logic      spiSdoOe,      // SPI data out enable
    input  wire logic resetLineIn,   // reset line level
    output logic      resetLineOut,  // reset line drive value
    output logic      resetLineOe,   // reset line pulled low
    output logic      busReceive,    // receive data pin
    output logic      mcuSupplyEn,   // mcu supply on
    output logic      auxSupplyEn,   // auxiliary supply on
    output logic      canTxEn,       // transmitter active
    output logic      canRxEn,       // receiver active
    output logic      canBiasEn,     // bus biasing, low means high-ohmic
    output logic      tempProtEn,    // temperature protection on
    output logic      wdgEnable      // watchdog allowed to run
);
    localparam int STARTUP_CYC = STARTUP_US * CLK_MHZ;
    localparam int RST_CYC     = RST_PULSE_US * CLK_MHZ;
    // =========================================================
    // pin synchronisers
    logic [SYNC_W-1:0] sync1;
    logic [SYNC_W-1:0] sync2;
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sync1 <= SYNC_RST;
            sync2 <= SYNC_RST;
        end else begin
            sync1 <= {batOk, tempWarn, tempOver, mcuSupplyUv, canSupplyUv,
                      canWakeDet, localWakeDet, diagWakeDet, wdgResetReq,
                      canRxBit, spiSck, spiSdi, spiSelect_n, resetLineIn};
            sync2 <= sync1;
        end
    end
    wire batS   = sync2[13], warnS  = sync2[12], overS  = sync2[11];
    wire mcuUvS = sync2[10], canUvS = sync2[9],  cWakeS = sync2[8];
    wire lWakeS = sync2[7],  dWakeS = sync2[6],  wdgS   = sync2[5];
    wire rxS    = sync2[4],  sckS   = sync2[3],  sdiS   = sync2[2];
    wire csS    = sync2[1],  rstInS = sync2[0];
    // =========================================================
    // state
    sbc_mode_type      mode, next_mode;
    logic [4:0]        reset_cause, next_rss;
    logic [CNT_W-1:0]  cnt;
    logic [7:0]        wakeCfg, auxCfg, canCfg, nvCfg;
    logic              spiFail, otwEvent, wakePend, normSeen, warnPrev;
    sbc_ctrl_type      ctrl, next_ctrl;
    logic              sckPrev, csPrev;
    logic [4:0]        bitCnt;
    logic [15:0]       rxShift;
    logic [7:0]        txShift, readData;
    wire forced_normal_cfg      = nvCfg[BIT_NV_FORCED_NORMAL_CFG];
    wire sleepInh  = nvCfg[BIT_NV_SLEEP_INH];
    wire canWakeEn = wakeCfg[BIT_CAN_WAKE_EN];
    wire locWakeEn = wakeCfg[BIT_LOC_WAKE_EN];
    wire anyWakeEn = canWakeEn | locWakeEn;
    wire rstDone   = cnt >= CNT_W'(RST_CYC - 1);
    wire bootDone  = cnt >= CNT_W'(STARTUP_CYC - 1);
    wire hostMode  = mode == SBC_STBY || mode == SBC_NORM;
    wire runMode   = hostMode || mode == SBC_FNORM;

    // =========================================================
    // SPI frame decode
    sbc_spi_frame_type frame;
    assign frame = sbc_spi_frame_type'(rxShift);
    wire sckRise  = sckS & ~sckPrev;
    wire sckFall  = ~sckS & sckPrev;
    wire csFall   = ~csS & csPrev;
    wire csRise   = csS & ~csPrev;
    wire spiWrite = csRise && bitCnt == SPI_BITS && !frame.readOnly
                    && ctrl.spiActive;
    wire [6:0] hdrAddr = rxShift[6:0];
    // (R21) forced normal read limits
    wire readOk   = mode != SBC_FNORM || hdrAddr == ADDR_MAIN
                    || hdrAddr == ADDR_NV;
    // (R21) nv writes only while preset
    wire nvWrite  = spiWrite && frame.addr == ADDR_NV && forced_normal_cfg;
    wire modeWr   = spiWrite && frame.addr == ADDR_MODE;
    wire evWrite  = spiWrite && frame.addr == ADDR_EVENT;
    wire [2:0] code = frame.data[2:0];
    // (R07) inhibited sleep flags failure
    wire sleepReq   = modeWr && hostMode && code == MODE_SLEEP;
    wire spiFailSet = sleepReq && sleepInh;
    // (R16) no wake detection in overtemp
    wire anyWake  = (cWakeS & canWakeEn) | (lWakeS & locWakeEn) | dWakeS;
    wire wakeDet  = mode != SBC_OTEMP && mode != SBC_OFF && anyWake;
    // (R15) warning crossing edge
    wire warnRise = warnS & ~warnPrev;
    wire otwSet   = warnRise && wakeCfg[BIT_OTW_IRQ_EN];
    wire extRst   = runMode && !rstInS;
    // (R23) mode code readback, upper bits zero
    logic [2:0] modeCode;
    assign modeCode = mode == SBC_NORM ? MODE_NORM :
                      mode == SBC_STBY ? MODE_STBY : 3'b000;
    always_comb begin
        case (readOk ? hdrAddr : 7'h00)
            ADDR_MODE:  readData = {5'b00000, modeCode};
            // (R24) main status report
            ADDR_MAIN:  readData = {1'b0, warnS, ~normSeen, reset_cause};
            ADDR_WCFG:  readData = wakeCfg;
            ADDR_AUX:   readData = auxCfg;
            ADDR_CAN:   readData = canCfg;
            ADDR_EVENT: readData = {5'b00000, wakePend, otwEvent, spiFail};
            ADDR_NV:    readData = nvCfg;
            default:    readData = 8'h00;
        endcase
    end

    // =========================================================
    // mode transitions, later checks take priority
    always_comb begin
        next_mode = mode;
        next_rss  = reset_cause;
        case (mode)
            SBC_OFF: begin
                // (R13) startup delay then reset
                if (bootDone) begin
                    next_mode = SBC_RESET;
                    next_rss  = RSS_POWER_ON;
                end
            end
            SBC_RESET: begin
                // (R10) (R11) (R12) reset exit
                if (rstDone && !mcuUvS && rstInS) begin
                    next_mode = forced_normal_cfg ? SBC_FNORM : SBC_STBY;
                end
            end
            SBC_STBY, SBC_NORM: begin
                if (modeWr) begin
                    // (R01) (R02) (R26) mode commands
                    if (code == MODE_STBY && mode == SBC_NORM) begin
                        next_mode = SBC_STBY;
                    end else if (code == MODE_NORM && mode == SBC_STBY) begin
                        next_mode = SBC_NORM;
                    end else if (code == MODE_SLEEP && !sleepInh) begin
                        // (R03) (R04) sleep preconditions
                        if (wakePend || wakeDet || !anyWakeEn) begin
                            next_mode = SBC_RESET;
                            next_rss  = RSS_ILL_SLP;
                        end else begin
                            next_mode = SBC_SLEEP;
                        end
                    end
                end
            end
            SBC_SLEEP: begin
                // (R06) wake from sleep
                if (anyWake) begin
                    next_mode = SBC_RESET;
                    next_rss  = cWakeS && canWakeEn ? RSS_CAN_WAKE :
                                lWakeS && locWakeEn ? RSS_LOC_WAKE : RSS_DIAG;
                end
            end
            SBC_OTEMP: begin
                // (R17) cooled down
                if (!overS) begin
                    next_mode = SBC_RESET;
                    next_rss  = RSS_OTEMP;
                end
            end
            SBC_FNORM: next_mode = SBC_FNORM;
            default:   next_mode = SBC_OFF;
        endcase
        // (R08) reset events
        if (runMode && (mcuUvS || extRst || wdgS)) begin
            next_mode = SBC_RESET;
            next_rss  = mcuUvS ? RSS_MCU_UV : extRst ? RSS_EXT_RST : RSS_WDG;
        end
        // (R14) overtemperature entry
        if (overS && mode != SBC_OFF && mode != SBC_SLEEP) begin
            next_mode = SBC_OTEMP;
        end
        // (R13) (R17) battery loss
        if (!batS) next_mode = SBC_OFF;
    end

    // =========================================================
    // per-mode hardware control
    always_comb begin
        next_ctrl = '0;
        case (next_mode)
            SBC_RESET: begin
                // (R09) (R20) reset mode hardware
                next_ctrl.mcuSupplyEn = 1'b1;
                next_ctrl.auxSupplyEn = auxCfg[0];
                next_ctrl.canTxEn     = forced_normal_cfg && !canUvS;
                next_ctrl.canBiasEn   = 1'b1;
                next_ctrl.tempProtEn  = 1'b1;
            end
            SBC_STBY, SBC_NORM: begin
                next_ctrl.mcuSupplyEn = 1'b1;
                next_ctrl.auxSupplyEn = auxCfg[0];
                next_ctrl.canBiasEn   = 1'b1;
                next_ctrl.tempProtEn  = 1'b1;
                next_ctrl.wdgEnable   = 1'b1;
                next_ctrl.spiActive   = 1'b1;
                next_ctrl.canTxEn     = next_mode == SBC_NORM && ^canCfg[1:0];
                next_ctrl.canRxEn     = next_mode == SBC_NORM && |canCfg[1:0];
            end
            SBC_SLEEP: begin
                // (R05) sleep hardware
                next_ctrl.auxSupplyEn = auxCfg[0];
                next_ctrl.canBiasEn   = 1'b1;
                next_ctrl.wdgEnable   = 1'b1;
            end
            SBC_FNORM: begin
                // (R18) forced normal hardware
                next_ctrl             = '1;
                next_ctrl.wdgEnable   = 1'b0;
            end
            SBC_OTEMP: begin
                // (R16) all off, detection kept
                next_ctrl.tempProtEn  = 1'b1;
            end
            default: next_ctrl = '0;
        endcase
    end

    // =========================================================
    // mode, counter and status flags
    // (R12) undervoltage restarts the reset pulse
    wire cntClr = next_mode != mode || (mode == SBC_RESET && mcuUvS)
                  || (mode == SBC_OFF && !batS);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            mode     <= SBC_OFF;
            reset_cause      <= RSS_POWER_ON;
            cnt      <= '0;
            ctrl     <= '0;
            normSeen <= 1'b0;
            warnPrev <= 1'b0;
            spiFail  <= 1'b0;
            otwEvent <= 1'b0;
            wakePend <= 1'b0;
        end else begin
            mode     <= next_mode;
            reset_cause      <= next_rss;
            ctrl     <= next_ctrl;
            warnPrev <= warnS;
            if (cntClr) cnt <= '0;
            else if (!cnt[CNT_W-1]) cnt <= cnt + CNT_W'(1);
            if (next_mode == SBC_NORM) normSeen <= 1'b1;
            // set wins over write-one-to-clear
            spiFail  <= spiFailSet
                        | (spiFail & ~(evWrite & frame.data[BIT_EV_SPI_FAIL]));
            otwEvent <= otwSet
                        | (otwEvent & ~(evWrite & frame.data[BIT_EV_OTW]));
            wakePend <= wakeDet
                        | (wakePend & ~(evWrite & frame.data[BIT_EV_WAKE]));
        end
    end

    // =========================================================
    // configuration registers
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            wakeCfg <= WCFG_RST;
            auxCfg  <= 8'h00;
            canCfg  <= 8'h00;
            // (R19) factory preset
            nvCfg   <= NV_RST;
        end else begin
            if (spiWrite && frame.addr == ADDR_WCFG) wakeCfg <= frame.data;
            if (spiWrite && frame.addr == ADDR_AUX)  auxCfg  <= frame.data;
            if (spiWrite && frame.addr == ADDR_CAN)  canCfg  <= frame.data;
            if (nvWrite)                             nvCfg   <= frame.data;
        end
    end

    // =========================================================
    // SPI shifter, sampled on rising SCK, shifted out on falling
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            sckPrev <= 1'b0;
            csPrev  <= 1'b1;
            bitCnt  <= '0;
            rxShift <= '0;
            txShift <= '0;
        end else begin
            sckPrev <= sckS;
            csPrev  <= csS;
            if (csFall) begin
                bitCnt  <= '0;
                txShift <= '0;
            end else if (!csS && sckRise && bitCnt != SPI_BITS) begin
                rxShift <= {rxShift[14:0], sdiS};
                bitCnt  <= bitCnt + 5'd1;
                if (bitCnt == SPI_HDR - 5'd1) txShift <= readData;
            end else if (!csS && sckFall && bitCnt > SPI_HDR) begin
                txShift <= {txShift[6:0], 1'b0};
            end
        end
    end

    // =========================================================
    // pin outputs
    // (R22) (R25) (R16) receive pin source
    wire rxPass = mode == SBC_FNORM || (mode == SBC_NORM && |canCfg[1:0]);
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            busReceive  <= 1'b1;
            resetLineOe <= 1'b1;
        end else begin
            busReceive  <= rxPass ? rxS : mode == SBC_OFF ? 1'b1 : ~wakePend;
            // (R09) reset line held for the pulse
            resetLineOe <= !(runMode || (mode == SBC_RESET && rstDone));
        end
    end
    assign resetLineOut = 1'b0;
    assign spiSdo       = txShift[7];
    assign spiSdoOe     = !csS && ctrl.spiActive;
    assign {mcuSupplyEn, auxSupplyEn, canTxEn, canRxEn, canBiasEn,
            tempProtEn, wdgEnable} = ctrl[7:1];
endmodule
